// file: obcd_top.sv
// Summary of operation
// R1: mode 10, level 011: interrupt and reset thresholds
// R2: mode 11, level 011: reset-only, four thresholds
// R3: mode 01, level 011: interrupt-only, same thresholds
// R4: lower mode bit and top level bit: detector off
// R5: detector byte bit 4 programmed as one
// R6: speed field 10 selects low-speed main mode
// R7: speed field 11 high-speed; others prohibited
// R8: oscillator code table, others prohibited
// R9: speed byte bit 5 one, bit 4 zero
// R10: debug 0/0 disables; 0/1 prohibited
// R11: debug 1/0 enables, erase on auth fail
// R12: debug 1/1 enables, keep flash on fail
// R13: debug bits 6:1 programmed as 000010
// R14: debug bits 3:1 not trusted on readback
// R15: fetch bytes after reset, then apply
// R16: detector off: reset only from external pin
// R17: prohibited combination raises configuration error
// R18: decoded outputs stable until next reset
//
// Decided for this implementation: the strobed register port.
`include "obcd_params.svh"

module obcd_top
  import obcd_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // flash read port
  output logic            FL_RD,
  output logic [7:0]      FL_ADDR,
  input  wire logic [7:0] FL_DATA,
  input  wire logic       FL_VALID,
  // software register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic [7:0]      REG_RDATA,
  // decoded configuration
  output logic            CFG_DONE,
  output logic            CFG_ERR,
  output logic [1:0]      DET_MODE,
  output logic [1:0]      DET_THRESHOLD,
  output logic            DET_LOW_FIXED,
  output logic            DET_DISABLED,
  output logic            PIN_RESET_ONLY,
  output logic            LOW_SPEED_MAIN,
  output logic            HIGH_SPEED_MAIN,
  output logic [2:0]      OSC_FREQ_SEL,
  output logic            DEBUG_ENABLE,
  output logic            KEEP_FLASH_ON_AUTH_FAIL
);

  obcd_state_e state_reg;
  logic [7:0]  det_byte_reg;
  logic [7:0]  spd_byte_reg;
  logic [7:0]  dbg_byte_reg;
  obcd_det_s   det_dec;
  obcd_speed_s spd_dec;
  obcd_debug_s dbg_dec;
  logic [5:0]  err_next;

  ////////////////////////////////////////////////////////////////////////////
  // fetch sequencer: one flash read per byte, waits for valid

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= OBCD_ST_IDLE;
    end else begin
      case (state_reg)
        OBCD_ST_IDLE:  state_reg <= OBCD_ST_DET; // R15
        OBCD_ST_DET:   if (FL_VALID) state_reg <= OBCD_ST_SPEED;
        OBCD_ST_SPEED: if (FL_VALID) state_reg <= OBCD_ST_DEBUG;
        OBCD_ST_DEBUG: if (FL_VALID) state_reg <= OBCD_ST_RUN;
        OBCD_ST_RUN:   state_reg <= OBCD_ST_RUN; // R18
        default:       state_reg <= OBCD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      FL_RD   <= 1'b0;
      FL_ADDR <= `OBCD_ADDR_DET;
    end else begin
      FL_RD <= 1'b0;
      case (state_reg)
        OBCD_ST_IDLE: begin
          FL_RD   <= 1'b1; // R15
          FL_ADDR <= `OBCD_ADDR_DET;
        end
        OBCD_ST_DET: if (FL_VALID) begin
          FL_RD   <= 1'b1;
          FL_ADDR <= `OBCD_ADDR_SPEED;
        end
        OBCD_ST_SPEED: if (FL_VALID) begin
          FL_RD   <= 1'b1;
          FL_ADDR <= `OBCD_ADDR_DEBUG;
        end
        default: FL_RD <= 1'b0;
      endcase
    end
  end

  // bytes captured once; no software path changes them
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      det_byte_reg <= `OBCD_BYTE_RST;
      spd_byte_reg <= `OBCD_BYTE_RST;
      dbg_byte_reg <= `OBCD_BYTE_RST;
    end else if (FL_VALID) begin
      if (state_reg == OBCD_ST_DET)   det_byte_reg <= FL_DATA; // R15 R18
      if (state_reg == OBCD_ST_SPEED) spd_byte_reg <= FL_DATA;
      if (state_reg == OBCD_ST_DEBUG) dbg_byte_reg <= FL_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  obcd_decode u_decode (
    .det_byte (det_byte_reg),
    .spd_byte (spd_byte_reg),
    .dbg_byte (dbg_byte_reg),
    .det      (det_dec),
    .spd      (spd_dec),
    .dbg      (dbg_dec)
  );

  // fixed bits are checked as well; debug bits 3:1 are ignored
  always_comb begin
    err_next = '0;
    err_next[`OBCD_ST_ERR_DET] = det_dec.err || !det_byte_reg[`OBCD_DET_FIXED1]; // R5 R17
    err_next[`OBCD_ST_ERR_SPD] = spd_dec.err_speed
                                 || !spd_byte_reg[`OBCD_SPD_FIXED1]
                                 || spd_byte_reg[`OBCD_SPD_FIXED0]; // R9 R17
    err_next[`OBCD_ST_ERR_OSC] = spd_dec.err_osc; // R17
    err_next[`OBCD_ST_ERR_DBG] = dbg_dec.err
                                 || (dbg_byte_reg[6:4] != `OBCD_DBG_STABLE); // R13 R14 R17
    err_next[`OBCD_ST_ERR_ANY] = |err_next[4:1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: apply decoded values once the last byte has landed

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CFG_DONE                <= 1'b0;
      CFG_ERR                 <= 1'b0;
      DET_MODE                <= OBCD_DET_OFF;
      DET_THRESHOLD           <= OBCD_THR_281;
      DET_LOW_FIXED           <= 1'b0;
      DET_DISABLED            <= 1'b1;
      PIN_RESET_ONLY          <= 1'b1;
      LOW_SPEED_MAIN          <= 1'b0;
      HIGH_SPEED_MAIN         <= 1'b0;
      OSC_FREQ_SEL            <= OBCD_OSC_32M;
      DEBUG_ENABLE            <= 1'b0;
      KEEP_FLASH_ON_AUTH_FAIL <= 1'b0;
    end else if (state_reg == OBCD_ST_RUN && !CFG_DONE) begin
      CFG_DONE                <= 1'b1; // R15 R18
      CFG_ERR                 <= err_next[`OBCD_ST_ERR_ANY]; // R17
      DET_MODE                <= det_dec.mode; // R1 R2 R3 R4
      DET_THRESHOLD           <= det_dec.thr;
      DET_LOW_FIXED           <= det_dec.low_fixed;
      DET_DISABLED            <= (det_dec.mode == OBCD_DET_OFF); // R4
      PIN_RESET_ONLY          <= det_dec.pin_reset_only; // R16
      LOW_SPEED_MAIN          <= spd_dec.low_speed_main; // R6
      HIGH_SPEED_MAIN         <= spd_dec.high_speed_main; // R7
      OSC_FREQ_SEL            <= spd_dec.osc; // R8
      DEBUG_ENABLE            <= dbg_dec.debug_enable; // R10 R11 R12
      KEEP_FLASH_ON_AUTH_FAIL <= dbg_dec.keep_flash_on_auth_fail; // R11 R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: read only, writes ignored

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= 8'h00;
      if (REG_RD) begin
        if (REG_ADDR == `OBCD_REG_DET) begin
          REG_RDATA <= det_byte_reg;
        end else if (REG_ADDR == `OBCD_REG_SPEED) begin
          REG_RDATA <= spd_byte_reg;
        end else if (REG_ADDR == `OBCD_REG_DEBUG) begin
          REG_RDATA <= dbg_byte_reg;
        end else if (REG_ADDR == `OBCD_REG_STATUS) begin
          REG_RDATA <= {2'h0, CFG_ERR ? err_next[5:1] : 5'h00, CFG_DONE};
        end else begin
          REG_RDATA <= 8'h00;
        end
      end
    end
  end

endmodule : obcd_top

// file: obcd_params.svh
`ifndef OBCD_PARAMS_SVH
`define OBCD_PARAMS_SVH

// flash byte addresses of the configuration bytes
`define OBCD_ADDR_DET      8'hc1
`define OBCD_ADDR_SPEED    8'hc2
`define OBCD_ADDR_DEBUG    8'hc3

// register offsets on the software port
`define OBCD_REG_DET       8'hc1
`define OBCD_REG_SPEED     8'hc2
`define OBCD_REG_DEBUG     8'hc3
`define OBCD_REG_STATUS    8'hc4

// detector byte field positions
`define OBCD_DET_MODE_LO   0
`define OBCD_DET_MODE_HI   1
`define OBCD_DET_THR_LO    2
`define OBCD_DET_THR_HI    3
`define OBCD_DET_FIXED1    4
`define OBCD_DET_LVL_LOW   5
`define OBCD_DET_LVL_MID   6
`define OBCD_DET_LVL_TOP   7

// speed byte field positions
`define OBCD_SPD_FIXED0    4
`define OBCD_SPD_FIXED1    5

// debug byte fixed pattern on bits 6:1, and the stable part 6:4
`define OBCD_DBG_PATTERN   6'h02
`define OBCD_DBG_STABLE    3'h0

// status bit positions
`define OBCD_ST_DONE       0
`define OBCD_ST_ERR_DET    1
`define OBCD_ST_ERR_SPD    2
`define OBCD_ST_ERR_OSC    3
`define OBCD_ST_ERR_DBG    4
`define OBCD_ST_ERR_ANY    5

// reset values
`define OBCD_BYTE_RST      8'h00

`endif

// file: obcd_pkg.sv
package obcd_pkg;

  typedef enum logic [1:0] {
    OBCD_DET_OFF   = 2'h0,
    OBCD_DET_INT   = 2'h1,
    OBCD_DET_RST   = 2'h2,
    OBCD_DET_INTRST = 2'h3
  } obcd_detmode_e;

  // threshold index: 0=2.81/2.75 1=2.92/2.86 2=3.02/2.96 3=3.13/3.06
  typedef enum logic [1:0] {
    OBCD_THR_281 = 2'h0,
    OBCD_THR_292 = 2'h1,
    OBCD_THR_302 = 2'h2,
    OBCD_THR_313 = 2'h3
  } obcd_thr_e;

  typedef enum logic [2:0] {
    OBCD_OSC_32M = 3'h0,
    OBCD_OSC_24M = 3'h1,
    OBCD_OSC_16M = 3'h2,
    OBCD_OSC_12M = 3'h3,
    OBCD_OSC_8M  = 3'h4,
    OBCD_OSC_4M  = 3'h5,
    OBCD_OSC_1M  = 3'h6
  } obcd_osc_e;

  typedef enum logic [4:0] {
    OBCD_ST_IDLE  = 5'h01,
    OBCD_ST_DET   = 5'h02,
    OBCD_ST_SPEED = 5'h04,
    OBCD_ST_DEBUG = 5'h08,
    OBCD_ST_RUN   = 5'h10
  } obcd_state_e;

  typedef struct packed {
    obcd_detmode_e mode;
    obcd_thr_e     thr;
    logic          low_fixed;
    logic          pin_reset_only;
    logic          err;
  } obcd_det_s;

  typedef struct packed {
    logic      high_speed_main;
    logic      low_speed_main;
    obcd_osc_e osc;
    logic      err_speed;
    logic      err_osc;
  } obcd_speed_s;

  typedef struct packed {
    logic debug_enable;
    logic keep_flash_on_auth_fail;
    logic err;
  } obcd_debug_s;

endpackage : obcd_pkg

// file: obcd_decode.sv
`include "obcd_params.svh"

module obcd_decode
  import obcd_pkg::*;
(
  input  wire logic [7:0] det_byte,
  input  wire logic [7:0] spd_byte,
  input  wire logic [7:0] dbg_byte,
  output obcd_det_s       det,
  output obcd_speed_s     spd,
  output obcd_debug_s     dbg
);

  logic [2:0] lvl;
  logic [1:0] thr_code;
  logic [1:0] mode_bits;

  assign lvl       = det_byte[`OBCD_DET_LVL_TOP:`OBCD_DET_LVL_LOW];
  assign thr_code  = det_byte[`OBCD_DET_THR_HI:`OBCD_DET_THR_LO];
  assign mode_bits = det_byte[`OBCD_DET_MODE_HI:`OBCD_DET_MODE_LO];

  always_comb begin
    det = '{mode: OBCD_DET_OFF, thr: OBCD_THR_281, low_fixed: 1'b0,
            pin_reset_only: 1'b1, err: 1'b1};
    if (mode_bits[0] && lvl[2]) begin
      det.err = 1'b0; // R4 R16
    end else if (lvl == 3'h3) begin
      case (mode_bits)
        2'h2: begin
          det.mode           = OBCD_DET_INTRST;
          det.low_fixed      = 1'b1;
          det.pin_reset_only = 1'b0;
          det.err            = !(thr_code == 2'h2 || thr_code == 2'h1); // R1
          det.thr            = (thr_code == 2'h1) ? OBCD_THR_302 : OBCD_THR_292; // R1
        end
        2'h3, 2'h1: begin
          det.mode           = (mode_bits == 2'h3) ? OBCD_DET_RST : OBCD_DET_INT; // R2 R3
          det.pin_reset_only = (mode_bits != 2'h3);
          det.err            = 1'b0;
          det.thr            = obcd_thr_e'(2'h3 - thr_code); // R2 R3
        end
        default: begin
          det.err = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    spd = '{high_speed_main: 1'b0, low_speed_main: 1'b0, osc: OBCD_OSC_32M,
            err_speed: 1'b1, err_osc: 1'b0};
    case (spd_byte[7:6])
      2'h2: begin
        spd.low_speed_main = 1'b1; // R6
        spd.err_speed      = 1'b0;
      end
      2'h3: begin
        spd.high_speed_main = 1'b1; // R7
        spd.err_speed       = 1'b0;
      end
      default: spd.err_speed = 1'b1; // R7
    endcase
    case (spd_byte[3:0]) // R8
      4'h8:    spd.osc = OBCD_OSC_32M;
      4'h0:    spd.osc = OBCD_OSC_24M;
      4'h9:    spd.osc = OBCD_OSC_16M;
      4'h1:    spd.osc = OBCD_OSC_12M;
      4'ha:    spd.osc = OBCD_OSC_8M;
      4'hb:    spd.osc = OBCD_OSC_4M;
      4'hd:    spd.osc = OBCD_OSC_1M;
      default: spd.err_osc = 1'b1;
    endcase
  end

  always_comb begin
    dbg.debug_enable            = dbg_byte[7]; // R10 R11 R12
    dbg.keep_flash_on_auth_fail = dbg_byte[7] && dbg_byte[0]; // R11 R12
    dbg.err                     = !dbg_byte[7] && dbg_byte[0]; // R10
  end

endmodule : obcd_decode

// file: obcd_assertions.sv
module obcd_assertions (
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       FL_RD,
  input wire logic [7:0] FL_ADDR,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       CFG_DONE,
  input wire logic       CFG_ERR,
  input wire logic [1:0] DET_MODE,
  input wire logic       DET_LOW_FIXED,
  input wire logic       DET_DISABLED,
  input wire logic       PIN_RESET_ONLY,
  input wire logic       LOW_SPEED_MAIN,
  input wire logic       HIGH_SPEED_MAIN,
  input wire logic [2:0] OSC_FREQ_SEL,
  input wire logic       DEBUG_ENABLE,
  input wire logic       KEEP_FLASH_ON_AUTH_FAIL
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_rd_pulse: assert property (FL_RD |=> !FL_RD)
    else $error("flash read held too long");
  a_rd_addr: assert property (FL_RD |-> FL_ADDR inside {8'hc1, 8'hc2, 8'hc3})
    else $error("flash read outside config bytes");
  a_done_fetch: assert property (CFG_DONE |-> FL_ADDR == 8'hc3 && !FL_RD)
    else $error("applied before last byte fetched");
  a_cfg_frozen: assert property (CFG_DONE |=> CFG_DONE && $stable({CFG_ERR, DET_MODE,
    DET_DISABLED, LOW_SPEED_MAIN, HIGH_SPEED_MAIN, OSC_FREQ_SEL, DEBUG_ENABLE,
    KEEP_FLASH_ON_AUTH_FAIL}))
    else $error("decoded outputs moved");
  a_off_pin: assert property (DET_DISABLED |-> PIN_RESET_ONLY && DET_MODE == 2'h0)
    else $error("detector off but not pin reset");
  a_low_fixed: assert property (DET_LOW_FIXED |-> DET_MODE == 2'h3)
    else $error("low threshold outside combined mode");
  a_speed_one: assert property (CFG_DONE && !CFG_ERR |->
    LOW_SPEED_MAIN != HIGH_SPEED_MAIN)
    else $error("speed mode not exclusive");
  a_status_err: assert property (REG_RD && REG_ADDR == 8'hc4 |=>
    REG_RDATA[5] == $past(CFG_ERR) && REG_RDATA[0] == $past(CFG_DONE))
    else $error("status disagrees with flags");
endmodule : obcd_assertions

bind obcd_top obcd_assertions u_chk (.MCLK(MCLK), .RST_N(RST_N), .FL_RD(FL_RD),
  .FL_ADDR(FL_ADDR), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CFG_DONE(CFG_DONE), .CFG_ERR(CFG_ERR), .DET_MODE(DET_MODE),
  .DET_LOW_FIXED(DET_LOW_FIXED), .DET_DISABLED(DET_DISABLED),
  .PIN_RESET_ONLY(PIN_RESET_ONLY), .LOW_SPEED_MAIN(LOW_SPEED_MAIN),
  .HIGH_SPEED_MAIN(HIGH_SPEED_MAIN), .OSC_FREQ_SEL(OSC_FREQ_SEL),
  .DEBUG_ENABLE(DEBUG_ENABLE), .KEEP_FLASH_ON_AUTH_FAIL(KEEP_FLASH_ON_AUTH_FAIL));

// file: obcd_flash_model.sv
module obcd_flash_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rd,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] det_b,
  input  wire logic [7:0] spd_b,
  input  wire logic [7:0] dbg_b,
  input  wire logic [3:0] lat,
  output logic [7:0]      data,
  output logic            valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pend_reg;
  logic [3:0] cnt_reg;
  logic [7:0] byte_reg;
  // answers after lat extra cycles; idle bus churns so stale data never matches
  always_ff @(posedge clk) begin
    valid <= 1'b0;
    data  <= ~data;
    if (!rst_n) begin
      pend_reg <= 1'b0;
      data     <= 8'h5a;
    end else if (rd) begin
      pend_reg <= 1'b1;
      cnt_reg  <= lat;
      byte_reg <= (addr == 8'hc1) ? det_b : (addr == 8'hc2) ? spd_b : dbg_b;
    end else if (pend_reg && cnt_reg == 4'h0) begin
      pend_reg <= 1'b0;
      valid    <= 1'b1;
      data     <= byte_reg;
    end else if (pend_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule : obcd_flash_model

// file: obcd_top_test.sv
module obcd_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk      = 1'b0;
  logic       rst_n     = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] det_b     = 8'h00;
  logic [7:0] spd_b     = 8'h00;
  logic [7:0] dbg_b     = 8'h00;
  logic [3:0] lat       = 4'h0;
  logic [7:0] fl_addr, fl_data, reg_rdata;
  logic [1:0] det_mode, det_thr;
  logic [2:0] osc;
  logic       fl_rd, fl_valid, cfg_done, cfg_err, det_low, det_off, pin_rst;
  logic       slow_main, fast_main, dbg_en, keep;
  int         fail_count  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  obcd_top dut (
    .MCLK(mclk), .RST_N(rst_n), .FL_RD(fl_rd), .FL_ADDR(fl_addr), .FL_DATA(fl_data),
    .FL_VALID(fl_valid), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CFG_DONE(cfg_done), .CFG_ERR(cfg_err),
    .DET_MODE(det_mode), .DET_THRESHOLD(det_thr), .DET_LOW_FIXED(det_low),
    .DET_DISABLED(det_off), .PIN_RESET_ONLY(pin_rst), .LOW_SPEED_MAIN(slow_main),
    .HIGH_SPEED_MAIN(fast_main), .OSC_FREQ_SEL(osc), .DEBUG_ENABLE(dbg_en),
    .KEEP_FLASH_ON_AUTH_FAIL(keep));
  obcd_flash_model u_flash (.clk(mclk), .rst_n(rst_n), .rd(fl_rd), .addr(fl_addr),
    .det_b(det_b), .spd_b(spd_b), .dbg_b(dbg_b), .lat(lat), .data(fl_data),
    .valid(fl_valid));

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : reg_read

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic boot(input logic [7:0] d, input logic [7:0] s, input logic [7:0] g,
                      input logic [3:0] l);
    int n;
    det_b <= d;
    spd_b <= s;
    dbg_b <= g;
    lat   <= l;
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    check(fl_addr, 8'hc1);
    check(cfg_done, 1'b0);
    rst_n <= 1'b1;
    n = 0;
    while (cfg_done !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    check(cfg_done, 1'b1);
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_intrst;
    logic [7:0] d;
    boot(8'h7a, 8'had, 8'h85, 4'h0);
    check(det_mode, 2'h3);
    check(det_thr, 2'h1);
    check(det_low, 1'b1);
    check(slow_main, 1'b1);
    check(fast_main, 1'b0);
    check(osc, 3'h6);
    check(dbg_en, 1'b1);
    check(keep, 1'b1);
    reg_write(8'hc2, 8'h00);
    reg_read(8'hc2, d);
    check(d, 8'had);
    reg_read(8'hc4, d);
    check(d, 8'h01);
    reg_read(8'h10, d);
    check(d, 8'h00);
  endtask : t_intrst

  task automatic t_levels;
    logic [3:0] oscs [7] = '{4'h8, 4'h0, 4'h9, 4'h1, 4'ha, 4'hb, 4'hd};
    logic [1:0] modes [3] = '{2'b11, 2'b01, 2'b10};
    logic [1:0] m;
    logic [1:0] c;
    int         k;
    k = 0;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 4; j++) begin
        m = modes[i];
        c = j[1:0];
        if (m != 2'b10 || c == 2'b01 || c == 2'b10) begin
          boot({4'b0111, c, m}, {4'b1110, oscs[k % 7]}, 8'h04, k[3:0]);
          check(det_mode, (m == 2'b10) ? 2'h3 : {m[1], ~m[1]});
          check(det_thr, 2'(~c));
          check(det_low, m == 2'b10);
          check(det_off, 1'b0);
          check(pin_rst, !m[1]);
          check(fast_main, 1'b1);
          check(osc, k % 7);
          check(cfg_err, 1'b0);
          k++;
        end
      end
    end
  endtask : t_levels

  task automatic t_off_debug;
    logic [7:0] dbgs [4] = '{8'h04, 8'h84, 8'h85, 8'h8e};
    for (int i = 0; i < 4; i++) begin
      boot(i[0] ? 8'hf3 : 8'h91, 8'had, dbgs[i], 4'h9);
      check(det_off, 1'b1);
      check(det_mode, 2'h0);
      check(pin_rst, 1'b1);
      check(cfg_err, 1'b0);
      check(dbg_en, dbgs[i][7]);
      check(keep, dbgs[i][0]);
    end
  endtask : t_off_debug

  task automatic t_bad;
    logic [31:0] rows [9] = '{32'h5aed0423, 32'h7eed0423, 32'h6aed0423, 32'h7a6d0425,
                              32'h7aef0429, 32'h7afd0425, 32'h7aed0531, 32'h7aed4431,
                              32'h78ed0423};
    logic [7:0]  st;
    for (int i = 0; i < 9; i++) begin
      boot(rows[i][31:24], rows[i][23:16], rows[i][15:8], 4'h1);
      check(cfg_err, 1'b1);
      reg_read(8'hc4, st);
      check(st, rows[i][7:0]);
    end
  endtask : t_bad

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    t_intrst();
    t_levels();
    t_off_debug();
    t_bad();
    complete_run();
  end
endmodule : obcd_top_test
